/* File: ssfp_pkg.sv */
// shared constants and types of the serial frame sequencer
package ssfp_pkg;
  localparam int unsigned CLK_FREQ_HZ  = 25_000_000;
  localparam int unsigned SCLK_FREQ_HZ = 3_125_000;
  localparam int unsigned HALF_CYCLES  = CLK_FREQ_HZ / (2 * SCLK_FREQ_HZ);
  localparam logic [2:0]  HALF_CNT_MAX = 3'(HALF_CYCLES - 1);

  localparam int unsigned ADDR_W = 12;
  localparam int unsigned DATA_W = 32;

  localparam logic [11:0] REG_CTRL   = 12'h000;
  localparam logic [11:0] REG_STATUS = 12'h004;
  localparam logic [11:0] REG_TXDATA = 12'h008;
  localparam logic [11:0] REG_RXDATA = 12'h00C;

  localparam int unsigned CTRL_EN_BIT     = 0;
  localparam int unsigned CTRL_MASTER_BIT = 1;
  localparam int unsigned CTRL_POL_BIT    = 2;
  localparam int unsigned CTRL_PHA_BIT    = 3;
  localparam int unsigned CTRL_SIZE_LSB   = 4;
  localparam int unsigned CTRL_SIZE_MSB   = 7;
  localparam logic [7:0]  CTRL_RESET      = 8'h00;

  localparam int unsigned STAT_BUSY_BIT   = 0;
  localparam int unsigned STAT_TXFULL_BIT = 1;
  localparam int unsigned STAT_RXVAL_BIT  = 2;

  localparam logic [3:0]  MIN_SIZE_CODE = 4'h3;
  localparam logic [3:0]  MAX_SIZE_CODE = 4'hF;
  localparam logic [1:0]  TAIL_PH0      = 2'h1;
  localparam logic [1:0]  TAIL_PH1      = 2'h2;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_START = 2'b01,
    ST_SHIFT = 2'b11,
    ST_TAIL  = 2'b10
  } ssfp_state_type;
endpackage

/* File: ssfp_top.sv */
// serial frame sequencer for the four polarity and phase settings, master or slave
//
// The address map and the APB slave port were left to the implementer.
`timescale 1ns/1ps
module ssfp_top (
  input  wire logic                        pclk,
  input  wire logic                        presetn,
  input  wire logic                        psel,
  input  wire logic                        penable,
  input  wire logic                        pwrite,
  input  wire logic [ssfp_pkg::ADDR_W-1:0] paddr,
  input  wire logic [ssfp_pkg::DATA_W-1:0] pwdata,
  output logic      [ssfp_pkg::DATA_W-1:0] prdata,
  output logic                             pready,
  output logic                             pslverr,
  input  wire logic                        serial_clock_in,
  output logic                             serial_clock_out,
  output logic                             serial_clock_oe,
  input  wire logic                        frame_select_in,
  output logic                             frame_select_out,
  output logic                             frame_select_oe,
  input  wire logic                        serial_in_pin,
  output logic                             serial_out_pin,
  output logic                             serial_out_oe
);
  import ssfp_pkg::*;

  function automatic logic [3:0] size_code(input logic [3:0] c);
    return (c < MIN_SIZE_CODE) ? MIN_SIZE_CODE : c;
  endfunction

  function automatic logic [15:0] size_mask(input logic [3:0] b);
    return 16'hFFFF >> (MAX_SIZE_CODE - b);
  endfunction

  function automatic logic reg_mapped(input logic [11:0] a);
    return (a == REG_CTRL) || (a == REG_STATUS) || (a == REG_TXDATA) || (a == REG_RXDATA);
  endfunction

  logic [7:0]     ctrl_q;
  logic [15:0]    tx_data_q;
  logic           tx_valid_q;
  logic [15:0]    rx_data_q;
  logic           rx_valid_q;
  logic [15:0]    tx_shift_q;
  logic [15:0]    rx_shift_q;
  logic [31:0]    prdata_q;
  logic           pready_q;
  logic           pslverr_q;
  ssfp_state_type st_q;
  logic [2:0]     div_q;
  logic [5:0]     edge_q;
  logic [1:0]     tail_q;
  logic           sclk_q;
  logic           fss_q;
  logic           drive_q;
  logic           sclk_oe_q;
  logic           fss_oe_q;
  logic           out_q;
  logic           out_oe_q;
  logic           sclk_m1_q;
  logic           sclk_s_q;
  logic           fss_m1_q;
  logic           fss_s_q;
  logic           rx_m1_q;
  logic           rx_s_q;
  logic           sclk_prev_q;
  logic           fss_prev_q;
  logic [3:0]     s_cnt_q;
  logic           first_q;

  logic           en;
  logic           master;
  logic           pol;
  logic           pha;
  logic [3:0]     bits_m1;
  logic [5:0]     last_edge;
  logic [5:0]     last_samp;
  logic [5:0]     e;
  logic           tick;
  logic           start_ok;
  logic           in_shift;
  logic           m_load;
  logic           m_shift;
  logic           m_sample;
  logic           m_done;
  logic           s_active;
  logic           s_lead;
  logic           s_trail;
  logic           s_load;
  logic           s_shift;
  logic           s_sample;
  logic           s_done;
  logic           load;
  logic           shift;
  logic           sample;
  logic           done;
  logic           busy;
  logic           apb_setup;
  logic           apb_access;
  logic           wr_en;
  logic           rd_en;
  logic [31:0]    rd_value;

  assign en        = ctrl_q[CTRL_EN_BIT];
  assign master    = ctrl_q[CTRL_MASTER_BIT];
  assign pol       = ctrl_q[CTRL_POL_BIT];
  assign pha       = ctrl_q[CTRL_PHA_BIT];
  assign bits_m1   = size_code(ctrl_q[CTRL_SIZE_MSB:CTRL_SIZE_LSB]);
  assign last_edge = {1'b0, bits_m1, 1'b0} + 6'h02;
  assign last_samp = pha ? last_edge : last_edge - 6'h01;
  assign e         = edge_q + 6'h01;
  assign tick      = (div_q == HALF_CNT_MAX);
  assign start_ok  = en & master & tx_valid_q;
  assign in_shift  = (st_q == ST_SHIFT) & tick & en & master;

  // odd edges sample in phase zero, even edges in phase one
  assign m_sample = in_shift & (pha ? ~e[0] : e[0]);
  assign m_done   = m_sample & (e == last_samp);
  assign m_shift  = in_shift & (pha ? (e[0] & (e != 6'h01)) : (~e[0] & (e != last_edge)));
  assign m_load   = ((st_q == ST_IDLE) & tick & start_ok)
                  | (in_shift & pha & (e == last_edge) & start_ok);

  // slave edges come from the synchronised pin copies only
  assign s_active = en & ~master & ~fss_s_q;
  assign s_lead   = (sclk_s_q != pol) & (sclk_prev_q == pol);
  assign s_trail  = (sclk_s_q == pol) & (sclk_prev_q != pol);
  assign s_sample = s_active & (pha ? s_trail : s_lead);
  assign s_done   = s_sample & (s_cnt_q == bits_m1);
  assign s_shift  = s_active & (pha ? (s_lead & ~first_q) : s_trail);
  assign s_load   = (s_active & fss_prev_q) | (s_done & pha);

  assign load   = master ? m_load : s_load;
  assign shift  = master ? m_shift : s_shift;
  assign sample = master ? m_sample : s_sample;
  assign done   = master ? m_done : s_done;
  assign busy   = master ? (st_q != ST_IDLE) : s_active;

  // apb: one wait-free access phase, data registered during setup
  assign apb_setup  = psel & ~penable;
  assign apb_access = psel & penable & pready_q;
  assign wr_en      = apb_access & pwrite & ~pslverr_q;
  assign rd_en      = apb_access & ~pwrite & ~pslverr_q;

  always_comb begin
    rd_value = 32'h0000_0000;
    case (paddr)
      REG_CTRL:   rd_value = {24'h00_0000, ctrl_q};
      REG_STATUS: rd_value = {29'h0000_0000, rx_valid_q, tx_valid_q, busy};
      REG_TXDATA: rd_value = {16'h0000, tx_data_q};
      REG_RXDATA: rd_value = {16'h0000, rx_data_q};
      default:    rd_value = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h0000_0000;
    end else begin
      pready_q  <= apb_setup;
      pslverr_q <= apb_setup & ~reg_mapped(paddr);
      if (apb_setup) begin
        prdata_q <= rd_value;
      end
    end
  end

  // configuration must only be changed while disabled
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= CTRL_RESET;
    end else if (wr_en && paddr == REG_CTRL) begin
      ctrl_q <= pwdata[7:0];
    end
  end

  // a write landing with a load refills the holding word, so the set wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_data_q  <= 16'h0000;
      tx_valid_q <= 1'b0;
    end else if (wr_en && paddr == REG_TXDATA) begin
      tx_data_q  <= pwdata[15:0];
      tx_valid_q <= 1'b1;
    end else if (load) begin
      tx_valid_q <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_data_q  <= 16'h0000;
      rx_valid_q <= 1'b0;
    end else if (done) begin
      rx_data_q  <= {rx_shift_q[14:0], rx_s_q} & size_mask(bits_m1);
      rx_valid_q <= 1'b1;
    end else if (rd_en && paddr == REG_RXDATA) begin
      rx_valid_q <= 1'b0;
    end
  end

  // words are left aligned so the outgoing bit is always bit 15
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_shift_q <= 16'h0000;
      rx_shift_q <= 16'h0000;
    end else begin
      if (load) begin
        tx_shift_q <= tx_valid_q ? 16'(tx_data_q << (MAX_SIZE_CODE - bits_m1)) : 16'h0000;
      end else if (shift) begin
        tx_shift_q <= {tx_shift_q[14:0], 1'b0};
      end
      if (sample) begin
        rx_shift_q <= {rx_shift_q[14:0], rx_s_q};
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sclk_m1_q <= 1'b0;
      sclk_s_q  <= 1'b0;
      fss_m1_q  <= 1'b1;
      fss_s_q   <= 1'b1;
      rx_m1_q   <= 1'b0;
      rx_s_q    <= 1'b0;
    end else begin
      sclk_m1_q <= serial_clock_in;
      sclk_s_q  <= sclk_m1_q;
      fss_m1_q  <= frame_select_in;
      fss_s_q   <= fss_m1_q;
      rx_m1_q   <= serial_in_pin;
      rx_s_q    <= rx_m1_q;
    end
  end

  // free running half period divider; a frame start waits for the next tick
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_q <= 3'h0;
    end else begin
      div_q <= tick ? 3'h0 : div_q + 3'h1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q    <= ST_IDLE;
      edge_q  <= 6'h00;
      tail_q  <= 2'h0;
      sclk_q  <= 1'b0;
      fss_q   <= 1'b1;
      drive_q <= 1'b0;
    end else if (!en || !master) begin
      st_q    <= ST_IDLE;
      sclk_q  <= pol;
      fss_q   <= 1'b1;
      drive_q <= 1'b0;
    end else begin
      case (st_q)
        ST_IDLE: begin
          sclk_q  <= pol;
          fss_q   <= 1'b1;
          drive_q <= 1'b0;
          edge_q  <= 6'h00;
          if (tick && start_ok) begin
            fss_q <= 1'b0;
            st_q  <= pha ? ST_SHIFT : ST_START;
          end
        end
        ST_START: begin
          if (tick) begin
            drive_q <= 1'b1;
            st_q    <= ST_SHIFT;
          end
        end
        ST_SHIFT: begin
          if (tick) begin
            sclk_q <= ~sclk_q;
            edge_q <= e;
            if (pha && e == 6'h01) begin
              drive_q <= 1'b1;
            end
            if (e == last_edge) begin
              if (m_load) begin
                edge_q <= 6'h00;
              end else begin
                st_q   <= ST_TAIL;
                tail_q <= pha ? TAIL_PH1 : TAIL_PH0;
              end
            end
          end
        end
        ST_TAIL: begin
          if (tick) begin
            if (tail_q == 2'h1) begin
              fss_q   <= 1'b1;
              drive_q <= 1'b0;
              st_q    <= ST_IDLE;
            end else begin
              tail_q <= tail_q - 2'h1;
            end
          end
        end
        default: begin
          st_q  <= ST_IDLE;
          fss_q <= 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sclk_prev_q <= 1'b0;
      fss_prev_q  <= 1'b1;
      s_cnt_q     <= 4'h0;
      first_q     <= 1'b1;
    end else begin
      sclk_prev_q <= sclk_s_q;
      fss_prev_q  <= fss_s_q;
      if (!s_active || s_load) begin
        s_cnt_q <= 4'h0;
        first_q <= 1'b1;
      end else begin
        if (s_sample) begin
          s_cnt_q <= s_cnt_q + 4'h1;
        end
        if (pha && s_lead) begin
          first_q <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sclk_oe_q <= 1'b0;
      fss_oe_q  <= 1'b0;
      out_q     <= 1'b0;
      out_oe_q  <= 1'b0;
    end else begin
      sclk_oe_q <= master;
      fss_oe_q  <= master;
      out_q     <= ((master & drive_q) | s_active) ? tx_shift_q[15] : 1'b0;
      out_oe_q  <= master ? ~fss_q : s_active;
    end
  end

  assign prdata           = prdata_q;
  assign pready           = pready_q;
  assign pslverr          = pslverr_q;
  assign serial_clock_out = sclk_q;
  assign serial_clock_oe  = sclk_oe_q;
  assign frame_select_out = fss_q;
  assign frame_select_oe  = fss_oe_q;
  assign serial_out_pin   = out_q;
  assign serial_out_oe    = out_oe_q;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  chk_idle_low_clk: assert property ((master && !pol && st_q == ST_IDLE)[*2] |-> !sclk_q)
    else $error("idle clock not low");
  chk_idle_high_clk: assert property ((master && pol && st_q == ST_IDLE)[*2] |-> sclk_q)
    else $error("idle clock not high");
  chk_idle_pins: assert property ((master && st_q == ST_IDLE)[*3] |-> fss_q && !out_q)
    else $error("idle select or data wrong");
  chk_clk_pad_mode: assert property (##1 sclk_oe_q == $past(master))
    else $error("clock pad enable does not follow mode");
  chk_frame_start: assert property ($fell(fss_q) |-> $past(start_ok))
    else $error("frame began without data or enable");
  chk_tx_pad_on: assert property (master && !fss_q |=> out_oe_q)
    else $error("data pad off during frame");
  chk_ph0_first_edge: assert property ($fell(fss_q) && !pha |-> sclk_q == pol [*8] ##1 sclk_q != pol)
    else $error("phase zero first edge not one period after select");
  chk_ph1_first_edge: assert property ($fell(fss_q) && pha |-> sclk_q == pol [*4] ##1 sclk_q != pol)
    else $error("phase one first edge not half period after select");
  chk_sample_level: assert property (m_sample |-> sclk_q == (pol ^ pha) ##1 sclk_q != (pol ^ pha))
    else $error("sample on wrong clock edge");
  chk_tail_release: assert property (m_done && !m_load |-> ##9 $rose(fss_q))
    else $error("select not released one period after last sample");
  chk_cont_hold_low: assert property (m_done && m_load |=> !fss_q [*8])
    else $error("select rose inside continuous transfer");
  chk_edge_bound: assert property (st_q == ST_SHIFT |-> edge_q <= last_edge)
    else $error("edge count beyond word length");
  chk_rx_width: assert property ($rose(rx_valid_q) |-> (rx_data_q & ~size_mask(bits_m1)) == 16'h0000)
    else $error("received word wider than size");

  cov_ph0_back_to_back: cover property (!pha && $rose(fss_q) ##[1:12] $fell(fss_q));
  cov_ph1_continuous: cover property (pha && m_done && m_load);
  cov_slave_word: cover property (s_done);
  cov_pol1_frame: cover property (pol && $fell(fss_q));
endmodule

/* File: ssfp_spi_slave_model.sv */
// behavioural far-side slave of the serial frame sequencer
`timescale 1ns/1ps
module ssfp_spi_slave_model (
  input  wire logic        sclk,
  input  wire logic        sel_n,
  input  wire logic        mosi,
  input  wire logic        pol,
  input  wire logic        pha,
  input  wire logic [15:0] tx_word,
  input  wire logic [4:0]  nbits,
  output logic             miso,
  output logic [15:0]      rx_word,
  output int               rx_count
);
  int idx;

  initial begin
    miso     = 1'b0;
    rx_word  = 16'h0000;
    rx_count = 0;
    idx      = -1;
  end

  // shifter loads on select fall, and in phase one again after every nbits samples while selected
  always @(negedge sel_n) begin
    idx      = int'(nbits) - 1;
    rx_count = 0;
    if (!pha) begin
      miso = tx_word[idx];
      idx  = idx - 1;
    end
  end

  // no pull on the line: once released it must not keep the last bit
  always @(posedge sel_n) miso = ~miso;

  always @(sclk) begin
    if (sel_n === 1'b0 && sclk === (pol ~^ pha)) begin
      rx_word  = {rx_word[14:0], mosi};
      rx_count = rx_count + 1;
      if (pha && (rx_count % int'(nbits)) == 0) idx = int'(nbits) - 1;
    end else if (sel_n === 1'b0 && idx >= 0) begin
      miso = tx_word[idx];
      idx  = idx - 1;
    end
  end
endmodule

/* File: test_ssfp_top.sv */
// self-checking bench of the serial frame sequencer
`timescale 1ns/1ps
module test_ssfp_top;
  import ssfp_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        sclk_in, fss_in, sin_tb, sin_pin, slave_mode;
  logic        sclk_out, sclk_oe, fss_out, fss_oe, sout, sout_oe;
  logic        m_pol, m_pha, m_miso;
  logic [15:0] m_tx, m_rx;
  logic [4:0]  m_bits;
  int          m_cnt, errors, tests_run;

  always #20 pclk = ~pclk;
  assign sin_pin = slave_mode ? sin_tb : m_miso;

  ssfp_top i_ssfp_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .serial_clock_in(sclk_in), .serial_clock_out(sclk_out),
    .serial_clock_oe(sclk_oe), .frame_select_in(fss_in), .frame_select_out(fss_out),
    .frame_select_oe(fss_oe), .serial_in_pin(sin_pin), .serial_out_pin(sout),
    .serial_out_oe(sout_oe));

  ssfp_spi_slave_model i_ssfp_spi_slave_model (.sclk(sclk_out), .sel_n(fss_out | ~fss_oe),
    .mosi(sout), .pol(m_pol), .pha(m_pha), .tx_word(m_tx), .nbits(m_bits), .miso(m_miso),
    .rx_word(m_rx), .rx_count(m_cnt));

  task report_and_stop;
    if (errors == 0 && tests_run > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  task chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH %s expected %0h seen %0h", name, exp, seen);
    end
  endtask

  task apb(input logic wr_en, input logic [11:0] a, input logic [31:0] wd,
           output logic [31:0] r, output logic e);
    int k;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr_en;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    // look at pready at the falling edge and take the answer there, before the rising edge ends the access
    for (k = 0; k < 50; k++) begin
      @(negedge pclk);
      if (pready === 1'b1) break;
      @(posedge pclk);
    end
    if (k == 50) begin
      errors++;
      report_and_stop();
    end
    r = prdata;
    e = pslverr;
    @(posedge pclk);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, d, r, e);
  endtask

  // follows one or more frames until select has rested high for 40 cycles
  task watch(input logic pha, output int trans, output int rises, output int first,
             output int gap, output logic oe_first);
    int   c, hi, t_last, t_prev, t_rise;
    logic ck, fs;
    trans = 0;
    rises = 0;
    first = -1;
    hi = 0;
    t_last = 0;
    t_prev = 0;
    t_rise = 0;
    oe_first = 1'b0;
    for (c = 0; c < 300 && fss_out !== 1'b0; c++) @(negedge pclk);
    if (c == 300) begin
      errors++;
      report_and_stop();
    end
    ck = sclk_out;
    fs = 1'b0;
    for (c = 0; c < 4000 && hi < 40; c++) begin
      @(negedge pclk);
      if (sclk_out !== ck) begin
        if (trans == 0) begin
          first = c + 1;
          oe_first = sout_oe;
        end
        trans++;
        t_prev = t_last;
        t_last = c;
      end
      if (fss_out === 1'b1 && fs === 1'b0) begin
        rises++;
        t_rise = c;
      end
      hi = (fss_out === 1'b1) ? hi + 1 : 0;
      ck = sclk_out;
      fs = fss_out;
    end
    if (c == 4000) begin
      errors++;
      report_and_stop();
    end
    gap = t_rise - (pha ? t_last : t_prev);
  endtask

  task setup_master(input logic pol, input logic pha, input int n, input logic [15:0] w);
    m_pol <= pol;
    m_pha <= pha;
    m_bits <= 5'(n);
    m_tx <= ~w;
    wr(REG_CTRL, {24'h0, 4'(n - 1), pha, pol, 2'b11});
    repeat (16) @(posedge pclk);
    chk("clock idle level", sclk_out, pol);
    chk("select idle", fss_out, 1'b1);
    chk("data idle", sout, 1'b0);
    chk("clock pad enable", sclk_oe, 1'b1);
  endtask

  task scen_regs;
    apb(1'b0, REG_CTRL, 32'h0, rd, err);
    chk("ctrl reset", rd, 32'h0);
    apb(1'b0, REG_STATUS, 32'h0, rd, err);
    chk("status reset", rd, 32'h0);
    apb(1'b0, 12'h010, 32'h0, rd, err);
    chk("unmapped read data", rd, 32'h0);
    chk("unmapped read error", err, 1'b1);
    apb(1'b1, 12'h014, 32'hFFFFFFFF, rd, err);
    chk("unmapped write error", err, 1'b1);
    wr(REG_CTRL, 32'hFFFFFFFE);
    apb(1'b0, REG_CTRL, 32'h0, rd, err);
    chk("ctrl readback", rd, 32'h000000FE);
    wr(REG_CTRL, 32'h0);
  endtask

  task scen_modes;
    int          sizes [4] = '{4, 16, 8, 7};
    int          i, n, trans, rises, first, gap;
    logic        oe1;
    logic [15:0] w, mask;
    for (i = 0; i < 4; i++) begin
      n = sizes[i];
      w = 16'hB4D2 >> i;
      mask = 16'((32'h1 << n) - 1);
      setup_master(i[1], i[0], n, w);
      fork
        watch(i[0], trans, rises, first, gap, oe1);
        wr(REG_TXDATA, {16'h0, w});
      join
      @(posedge pclk);
      chk("clock transitions", trans, 2 * n);
      chk("select rises", rises, 1);
      chk("first clock edge", first, i[0] ? 4 : 8);
      chk("select release", gap, 8);
      chk("data pad in frame", oe1, 1'b1);
      chk("word at far side", m_rx & mask, w & mask);
      apb(1'b0, REG_RXDATA, 32'h0, rd, err);
      chk("received word", rd, {16'h0, ~w & mask});
      chk("clock rest after", sclk_out, i[1]);
      chk("data pad after", sout_oe, 1'b0);
      wr(REG_CTRL, 32'h0);
    end
  endtask

  task scen_b2b;
    int   i, k, trans, rises, first, gap;
    logic oe1;
    for (i = 0; i < 2; i++) begin
      setup_master(i[0], i[0], 8, 16'h00A7);
      fork
        watch(i[0], trans, rises, first, gap, oe1);
        begin
          wr(REG_TXDATA, 32'h000000A7);
          for (k = 0; k < 300 && fss_out !== 1'b0; k++) @(posedge pclk);
          if (k == 300) begin
            errors++;
            report_and_stop();
          end
          wr(REG_TXDATA, 32'h000000A7);
        end
      join
      @(posedge pclk);
      chk("b2b clock transitions", trans, 32);
      chk("b2b select rises", rises, i[0] ? 1 : 2);
      chk("b2b select release", gap, 8);
      chk("b2b far side count", m_cnt, i[0] ? 16 : 8);
      chk("b2b far side word", m_rx & 16'h00FF, 16'h00A7);
      wr(REG_CTRL, 32'h0);
    end
  endtask

  task scen_slave;
    int         b, k;
    logic [7:0] din;
    logic [7:0] din_tx;
    din = 8'h5B;
    din_tx = 8'h96;
    slave_mode <= 1'b1;
    wr(REG_CTRL, 32'h00000071);
    wr(REG_TXDATA, 32'h00000096);
    repeat (4) @(posedge pclk);
    chk("slave clock pad off", sclk_oe, 1'b0);
    fss_in <= 1'b0;
    repeat (8) @(posedge pclk);
    for (b = 7; b >= 0; b--) begin
      sin_tb <= din[b];
      repeat (4) @(posedge pclk);
      sclk_in <= 1'b1;
      repeat (4) @(posedge pclk);
      chk("slave data bit", sout, {31'h0, din_tx[b]});
      if (b == 7) chk("slave data pad", sout_oe, 1'b1);
      sclk_in <= 1'b0;
    end
    repeat (4) @(posedge pclk);
    fss_in <= 1'b1;
    sin_tb <= ~sin_tb;
    for (k = 0; k < 100; k++) begin
      apb(1'b0, REG_STATUS, 32'h0, rd, err);
      if (rd[STAT_RXVAL_BIT] === 1'b1) break;
    end
    if (k == 100) begin
      errors++;
      report_and_stop();
    end
    apb(1'b0, REG_RXDATA, 32'h0, rd, err);
    chk("slave received word", rd, {24'h0, din});
    slave_mode <= 1'b0;
    wr(REG_CTRL, 32'h0);
  endtask

  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    sclk_in = 1'b0;
    fss_in = 1'b1;
    sin_tb = 1'b0;
    slave_mode = 1'b0;
    m_pol = 1'b0;
    m_pha = 1'b0;
    m_tx = 16'h0;
    m_bits = 5'd8;
    errors = 0;
    tests_run = 0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    scen_regs();
    scen_modes();
    scen_b2b();
    scen_slave();
    report_and_stop();
  end
endmodule
